// ### logic/wdog_pkg.sv
// Package of constants for the supervisory watchdog timer
// Functional notes
// - While enabled, missing refresh within the timeout asserts system reset.
// - Enable bit cleared stops the watchdog; no timeout reset then.
// - Elapsed time is held in a sixteen-bit counter.
// - Prescale field selects timeout of 16 ms times two to the field.
// - Refresh counts only as first bit set, then second bit set.
// - Every timeout sets the status flag for software to inspect later.
// - Status flag cleared by writing zero or external reset, not watchdog reset.
// - Setting enable starts the watchdog and clears its counters.
// - One bit-addressable control register; timeout field in bits 7:5, bit 4 unused.
package wdog_pkg;
    // ============================================================
    // Register map
    localparam logic [7:0] WDOG_CTRL_ADDR  = 8'hc0;
    localparam logic [7:0] WDOG_CTRL_RESET = 8'h00;
    localparam int         PRE_MSB         = 7;
    localparam int         PRE_LSB         = 5;
    localparam int         UNUSED_BIT      = 4;
    localparam int         REF1_BIT        = 3;
    localparam int         REF2_BIT        = 2;
    localparam int         STAT_BIT        = 1;
    localparam int         EN_BIT          = 0;
    // ============================================================
    // Timing
    localparam int         CLK_HZ          = 50_000_000;
    localparam int         BASE_TIMEOUT_MS = 16;
    localparam int         CNT_WIDTH       = 16;
    // Base period split across a tick prescaler and the 16-bit counter;
    // 512 ticks let the longest setting fill the counter exactly
    localparam int         TICKS_PER_BASE  = 512;
    // Rounded down, so a timeout comes slightly early rather than late
    localparam int         TICK_CYCLES_DEF = CLK_HZ / 1000 * BASE_TIMEOUT_MS / TICKS_PER_BASE;
    localparam int         RST_PULSE_CYC   = 16;
endpackage : wdog_pkg

// ### logic/wdog_tick.sv
// Divider producing one-cycle ticks for the watchdog counter
module wdog_tick #(
    parameter int DIV = wdog_pkg::TICK_CYCLES_DEF
) (
    input  wire logic mclk,
    input  wire logic sys_rst,
    input  wire logic clr,
    output logic      tick
);
    logic [19:0] cnt_ff;
    wire         at_end = (cnt_ff == 20'(DIV - 1));

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst)
            cnt_ff <= 20'h00000;
        else if (clr || at_end)
            cnt_ff <= 20'h00000;
        else
            cnt_ff <= cnt_ff + 20'h00001;
    end

    assign tick = at_end && !clr;
endmodule : wdog_tick

// ### logic/supervisory_watchdog_timer.sv
// Watchdog timer with bit-addressable control register and system reset output
module supervisory_watchdog_timer
    import wdog_pkg::*;
#(
    parameter int TICK_CYCLES = wdog_pkg::TICK_CYCLES_DEF
) (
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       bit_wr,
    input  wire logic [2:0] bit_sel,
    input  wire logic       bit_val,
    output logic [7:0]      reg_rdata,
    output logic            wdog_rst_out
);
    import wdog_pkg::*;

    // ============================================================
    // Control register fields and internal state
    logic [2:0]           pre_ff;
    logic                 ref1_ff;
    logic                 ref2_ff;
    logic                 stat_ff;
    logic                 en_ff;
    logic [CNT_WIDTH-1:0] cnt_ff;
    logic [4:0]           rst_cnt_ff;
    logic [7:0]           rdata_ff;

    wire hit      = (reg_addr == WDOG_CTRL_ADDR);
    wire byte_wr  = reg_wr && hit;
    wire bwr      = bit_wr && hit && !reg_wr;
    // Bit-addressable writes form the new value from the current image
    wire [7:0] cur_img = {pre_ff, 1'b0, ref1_ff, ref2_ff, stat_ff, en_ff};
    logic [7:0] bit_img;
    always_comb begin
        bit_img = cur_img;
        bit_img[bit_sel] = bit_val;
    end
    wire       any_wr  = byte_wr || bwr;
    wire [7:0] wr_img  = byte_wr ? reg_wdata : bit_img;

    // ============================================================
    // Refresh sequencing
    wire set_r1    = any_wr && wr_img[REF1_BIT] && !ref1_ff;
    wire set_r2    = any_wr && wr_img[REF2_BIT];
    wire refresh   = set_r2 && ref1_ff;
    wire en_rise   = any_wr && wr_img[EN_BIT] && !en_ff;

    // ============================================================
    // Timeout detection
    // Terminal count is worked out at 32 bits, so the longest setting
    // still lands on 16'hffff instead of wrapping to zero
    wire                 tick;
    wire [CNT_WIDTH-1:0] last_cnt = CNT_WIDTH'((TICKS_PER_BASE << pre_ff) - 1);
    // Greater-or-equal: a shorter prescale written mid-count still expires
    wire                 at_last  = (cnt_ff >= last_cnt);
    wire                 timeout  = en_ff && tick && at_last && !refresh;
    wire                 tick_clr = refresh || en_rise || !en_ff;
    wire                 cnt_clr  = !en_ff || en_rise || refresh || timeout;
    wire                 stat_clr = any_wr && !wr_img[STAT_BIT];

    wdog_tick #(.DIV(TICK_CYCLES)) u_tick (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .clr     (tick_clr),
        .tick    (tick)
    );

    // ============================================================
    // Configuration bits
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pre_ff <= WDOG_CTRL_RESET[PRE_MSB:PRE_LSB];
            en_ff  <= WDOG_CTRL_RESET[EN_BIT];
        end else if (any_wr) begin
            pre_ff <= wr_img[PRE_MSB:PRE_LSB];
            en_ff  <= wr_img[EN_BIT];
        end
    end

    // ============================================================
    // Refresh bits; a completed sequence self-clears both
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ref1_ff <= WDOG_CTRL_RESET[REF1_BIT];
            ref2_ff <= WDOG_CTRL_RESET[REF2_BIT];
        end else if (refresh) begin
            ref1_ff <= 1'b0;
            ref2_ff <= 1'b0;
        end else if (any_wr) begin
            ref1_ff <= wr_img[REF1_BIT] && (ref1_ff || set_r1);
            ref2_ff <= 1'b0;                      // Lone second bit ignored
        end
    end

    // ============================================================
    // Status: set wins over a software clear in the same cycle
    // The watchdog's own reset pulse never touches it
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst)
            stat_ff <= WDOG_CTRL_RESET[STAT_BIT];
        else if (timeout)
            stat_ff <= 1'b1;
        else if (stat_clr)
            stat_ff <= 1'b0;
    end

    // ============================================================
    // Elapsed-time counter
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst)
            cnt_ff <= '0;
        else if (cnt_clr)
            cnt_ff <= '0;
        else if (tick)
            cnt_ff <= cnt_ff + CNT_WIDTH'(1);
    end

    // ============================================================
    // Reset pulse; this block sits outside the reset it drives
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst)
            rst_cnt_ff <= 5'h00;
        else if (timeout)
            rst_cnt_ff <= 5'(RST_PULSE_CYC);
        else if (rst_cnt_ff != 5'h00)
            rst_cnt_ff <= rst_cnt_ff - 5'h01;
    end
    assign wdog_rst_out = (rst_cnt_ff != 5'h00);

    // ============================================================
    // Registered read data; unmapped addresses read zero
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst)
            rdata_ff <= 8'h00;
        else
            rdata_ff <= hit ? cur_img : 8'h00;
    end
    assign reg_rdata = rdata_ff;

    // ============================================================
    // Checks
    timeout_rst_a : assert property (
        @(posedge mclk) disable iff (sys_rst)
        timeout |=> wdog_rst_out [*8]
    ) else $error("no reset after timeout");

    pulse_len_a : assert property (
        @(posedge mclk) disable iff (sys_rst)
        $rose(wdog_rst_out) |-> wdog_rst_out [*8] ##1 wdog_rst_out [*8] ##1 !wdog_rst_out
    ) else $error("reset pulse length wrong");

    disabled_quiet_a : assert property (
        @(posedge mclk) disable iff (sys_rst)
        !en_ff |-> !timeout
    ) else $error("timeout while disabled");

    idle_clear_a : assert property (
        @(posedge mclk) disable iff (sys_rst)
        !en_ff |=> cnt_ff == '0
    ) else $error("counter runs while disabled");

    cnt_bound_a : assert property (
        @(posedge mclk) disable iff (sys_rst)
        en_ff && tick && at_last && !refresh |=> cnt_ff == '0 && wdog_rst_out
    ) else $error("counter past limit");

    count_step_a : assert property (
        @(posedge mclk) disable iff (sys_rst)
        en_ff && tick && !timeout && !any_wr |=> cnt_ff == $past(cnt_ff) + CNT_WIDTH'(1)
    ) else $error("counter step wrong");

    limit_val_a : assert property (
        @(posedge mclk) disable iff (sys_rst)
        ((32'(last_cnt) + 32'd1) >> pre_ff) == 32'(TICKS_PER_BASE)
    ) else $error("bad limit");

    refresh_order_a : assert property (
        @(posedge mclk) disable iff (sys_rst)
        refresh |-> ref1_ff
    ) else $error("refresh without first bit");

    status_set_a : assert property (
        @(posedge mclk) disable iff (sys_rst)
        timeout |=> stat_ff
    ) else $error("status not set");

    status_hold_a : assert property (
        @(posedge mclk) disable iff (sys_rst)
        stat_ff && !any_wr |=> stat_ff
    ) else $error("status lost");

    status_clear_a : assert property (
        @(posedge mclk) disable iff (sys_rst)
        stat_clr && !timeout |=> !stat_ff
    ) else $error("status not cleared by write");

    enable_clear_a : assert property (
        @(posedge mclk) disable iff (sys_rst)
        en_rise |=> cnt_ff == '0 && en_ff
    ) else $error("counter not cleared");

    refresh_clear_a : assert property (
        @(posedge mclk) disable iff (sys_rst)
        refresh |=> !ref1_ff && !ref2_ff && cnt_ff == '0
    ) else $error("refresh not applied");

    lone_second_a : assert property (
        @(posedge mclk) disable iff (sys_rst)
        set_r2 && !ref1_ff |=> !ref2_ff
    ) else $error("lone second bit kept");

    unused_zero_a : assert property (
        @(posedge mclk) disable iff (sys_rst)
        !rdata_ff[UNUSED_BIT]
    ) else $error("bit 4 not zero");

    // Main scenarios
    refresh_c    : cover property (@(posedge mclk) disable iff (sys_rst)
        refresh);
    timeout_c    : cover property (@(posedge mclk) disable iff (sys_rst)
        timeout);
    enable_c     : cover property (@(posedge mclk) disable iff (sys_rst)
        en_rise);
    stat_clr_c   : cover property (@(posedge mclk) disable iff (sys_rst)
        stat_ff && stat_clr);
    lone_sec_c   : cover property (@(posedge mclk) disable iff (sys_rst)
        set_r2 && !ref1_ff);
endmodule : supervisory_watchdog_timer

// ### dv/testbench.sv
// Self-checking bench for the supervisory watchdog timer
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import wdog_pkg::*;
    // ==========================================
    // Short tick keeps timeouts for prescale 0 to 3 within the 9000-cycle wait
    localparam int TC = 2;
    logic       mclk, sys_rst, reg_wr, bit_wr, bit_val, wdog_rst_out;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [2:0] bit_sel;
    int         n_fail, n_compared;

    supervisory_watchdog_timer #(.TICK_CYCLES(TC)) supervisory_watchdog_timer_inst (
        .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .bit_wr(bit_wr), .bit_sel(bit_sel), .bit_val(bit_val), .reg_rdata(reg_rdata),
        .wdog_rst_out(wdog_rst_out));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // ==========================================
    // Shared tasks
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic chk_range(input string what, input int lo, input int hi, input int got);
        n_compared++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : chk_range

    task automatic final_report;
        $display("Compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report

    task automatic wr(input logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= 8'hc0;
        reg_wr    <= 1'b1;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask : wr

    task automatic bw(input logic [2:0] s);
        @(posedge mclk);
        reg_addr <= 8'hc0;
        bit_wr   <= 1'b1;
        bit_sel  <= s;
        bit_val  <= 1'b1;
        @(posedge mclk);
        bit_wr   <= 1'b0;
    endtask : bw

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge mclk);
        reg_addr <= a;
        repeat (3) @(posedge mclk);
        #1;
        chk(what, exp, reg_rdata);
    endtask : rd

    // Bounded: a missing reset ends the run
    task automatic to_rst(output int n);
        n = 0;
        while (wdog_rst_out !== 1'b1) begin
            @(posedge mclk);
            #1;
            n++;
            if (n > 9000) begin
                chk("reset wait", 8'h01, 8'h00);
                final_report();
            end
        end
    endtask : to_rst
    // ==========================================
    // Scenarios
    task automatic t_reset;
        rd(8'hc0, 8'h00, "reset image");
        rd(8'h55, 8'h00, "unmapped read");
        $display("reset test done");
    endtask : t_reset

    task automatic t_timeout;
        int n;
        int p;
        wr(8'h01);
        to_rst(n);
        chk_range("timeout timeout_select_bit0", TC * TICKS_PER_BASE - 8, TC * TICKS_PER_BASE + 8, n);
        p = 0;
        while (wdog_rst_out === 1'b1 && p < 40) begin
            @(posedge mclk);
            #1;
            p++;
        end
        chk("pulse length", 8'h10, 8'(p));
        rd(8'hc0, 8'h03, "status kept");
        wr(8'h00);
        rd(8'hc0, 8'h00, "status cleared");
        p = 0;
        repeat (5000) begin
            @(posedge mclk);
            #1;
            p += int'(wdog_rst_out === 1'b1);
        end
        chk("disabled reset", 8'h00, 8'(p));
        $display("timeout test done");
    endtask : t_timeout

    task automatic t_refresh;
        int n;
        wr(8'h21);
        repeat (TC * TICKS_PER_BASE * 3 / 2) @(posedge mclk);
        bw(3'h2);
        rd(8'hc0, 8'h21, "lone second bit");
        bw(3'h3);
        rd(8'hc0, 8'h29, "first bit held");
        bw(3'h2);
        rd(8'hc0, 8'h21, "bits cleared");
        to_rst(n);
        chk_range("timeout timeout_select_bit1", 2 * TC * TICKS_PER_BASE - 8, 2 * TC * TICKS_PER_BASE + 8, n);
        wr(8'h00);
        $display("refresh test done");
    endtask : t_refresh

    // Watchdog reset keeps the flag, external reset clears it
    task automatic t_ext_rst;
        int n;
        repeat (20) @(posedge mclk);
        wr(8'h01);
        to_rst(n);
        wr(8'he3);
        rd(8'hc0, 8'he3, "long prescale, status kept");
        @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        rd(8'hc0, 8'h00, "external reset image");
        chk("reset out after ext reset", 8'h00, {7'h00, wdog_rst_out});
        $display("external reset test done");
    endtask : t_ext_rst

    initial begin
        n_fail = 0;
        n_compared = 0;
        sys_rst = 1'b1;
        {reg_wr, bit_wr, bit_val} = 3'h0;
        reg_addr = 8'hc0;
        reg_wdata = 8'h00;
        bit_sel = 3'h0;
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        t_reset();
        t_timeout();
        t_refresh();
        t_ext_rst();
        final_report();
    end
endmodule : testbench
